// File: src/tc_input_register_map.sv
// input register bank and value encoder for the thermocouple module
// ************************************************************
// Notes on behaviour
// R1: percent as signed 16-bit, 20000 is 100%
// R2: temperature signed 16-bit, 0.1 degC per lsb
// R3: counts are 16-bit words, signed or unsigned
// R4: output discrete bit one means closed/on
// R5: input discrete one means pulled low/active
// R6: holding registers kept in non-volatile storage
// R7: codes 0-7FFF positive, 8000-FFFF negative
// R8: downscale break always reports code 32768
// R9: upscale break reports per-type over-range code
// R10: status bit 14 set during identify blink
// R11: status bit 13 set in factory default mode
// R12: status bit 15 and bits 12-0 read zero
// R13: range selector 4 bits, ten defined codes
// R14: client reads these registers, read-only
// ************************************************************
`timescale 1ns/1ps
module tc_input_register_map
    import tc_input_pkg::*;
#(
    parameter int DATA_W = 16          // register word width
) (
    input  wire logic              clk_sys_in,       // 50 MHz system clock
    input  wire logic              rst_b_in,         // sync reset, active low
    // state sources inside the module
    input  wire logic              identify_in,      // identify blink active
    input  wire logic              default_mode_in,  // factory default mode
    input  wire logic [3:0]        range_low_in,     // group low selector
    input  wire logic [3:0]        range_high_in,    // group high selector
    input  wire logic              jcomp_off_low_in, // 1 = compensation off
    input  wire logic              jcomp_off_high_in,// 1 = compensation off
    // value encoder
    input  wire logic [DATA_W-1:0] conv_value_in,    // linearised value
    input  wire logic              open_sensor_detect_in, // break seen
    input  wire logic              break_downscale_in,    // 1 = downscale
    input  wire logic [3:0]        enc_range_in,     // selector for value
    input  wire logic              discrete_pin_in,  // raw discrete pin
    output logic [DATA_W-1:0]      enc_value_out,    // encoded reading
    output logic                   enc_negative_out, // reading is negative
    output logic                   discrete_bit_out, // reported input bit
    // register read port (read-input-registers function)
    input  wire logic              rd_req_in,        // read strobe
    input  wire logic [15:0]       rd_addr_in,       // word offset
    output logic [DATA_W-1:0]      rd_data_out,      // read data
    output logic                   rd_valid_out,     // one-cycle answer
    output logic                   rd_error_out      // unmapped offset
);

    // ************************************************************
    // captured register contents
    // ************************************************************
    logic [DATA_W-1:0] status_q;      // module status word
    logic [3:0]        range_low_q;   // group low selector
    logic [3:0]        range_high_q;  // group high selector
    logic              jcomp_low_q;   // group low compensation off
    logic              jcomp_high_q;  // group high compensation off

    // status word built from flags; unused bits held at zero
    wire logic [DATA_W-1:0] status_d =
        (DATA_W'(identify_in) << BIT_IDENTIFY)      // see R10
      | (DATA_W'(default_mode_in) << BIT_DEFAULT);  // see R11, see R12

    // sample sources each cycle so a read sees one consistent snapshot
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            status_q     <= RST_WORD;
            range_low_q  <= RST_RANGE;
            range_high_q <= RST_RANGE;
            jcomp_low_q  <= RST_JCOMP;
            jcomp_high_q <= RST_JCOMP;
        end else begin
            status_q     <= status_d;
            range_low_q  <= range_low_in;       // see R13
            range_high_q <= range_high_in;      // see R13
            jcomp_low_q  <= jcomp_off_low_in;
            jcomp_high_q <= jcomp_off_high_in;
        end
    end

    // ************************************************************
    // read decode
    // ************************************************************
    // read-only bank: there is no write path at all, see R14
    wire logic hit_status = (rd_addr_in == OFS_MODULE_STATUS);
    wire logic hit_rlow   = (rd_addr_in == OFS_RANGE_LOW);
    wire logic hit_rhigh  = (rd_addr_in == OFS_RANGE_HIGH);
    wire logic hit_jlow   = (rd_addr_in == OFS_JCOMP_LOW);
    wire logic hit_jhigh  = (rd_addr_in == OFS_JCOMP_HIGH);
    wire logic hit_any    = hit_status | hit_rlow | hit_rhigh
                          | hit_jlow | hit_jhigh;

    // selection; unmapped offsets read zero
    wire logic [DATA_W-1:0] rd_mux =
        hit_status ? status_q :
        hit_rlow   ? DATA_W'(range_low_q) :
        hit_rhigh  ? DATA_W'(range_high_q) :
        hit_jlow   ? DATA_W'(jcomp_low_q) :
        hit_jhigh  ? DATA_W'(jcomp_high_q) :
                     RST_WORD;

    // answer registered, one cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rd_data_out  <= RST_WORD;
            rd_valid_out <= 1'b0;
            rd_error_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_req_in;
            rd_error_out <= rd_req_in & ~hit_any;
            if (rd_req_in) begin
                rd_data_out <= rd_mux;
            end
        end
    end

    // ************************************************************
    // value encoder
    // ************************************************************
    // upscale break code per thermocouple type
    logic [DATA_W-1:0] up_code;       // over-range detent
    always_comb begin
        case (enc_range_in)                             // see R9
            RNG_TC_J: up_code = DATA_W'(UP_BRK_J);
            RNG_TC_K: up_code = DATA_W'(UP_BRK_K);
            RNG_TC_T: up_code = DATA_W'(UP_BRK_T);
            RNG_TC_R: up_code = DATA_W'(UP_BRK_R);
            RNG_TC_S: up_code = DATA_W'(UP_BRK_S);
            RNG_TC_E: up_code = DATA_W'(UP_BRK_E);
            RNG_TC_B: up_code = DATA_W'(UP_BRK_B);
            RNG_TC_N: up_code = DATA_W'(UP_BRK_N);
            // millivolt and reserved selectors saturate at the positive code ceiling 7FFF
            default:  up_code = DATA_W'(UP_BRK_S);
        endcase
    end

    // value already in 0.1 degC or 20000-per-100% form, passed through
    // break replaces it; downscale code is type independent
    wire logic [DATA_W-1:0] enc_d =
        !open_sensor_detect_in ? conv_value_in :    // see R1, see R2, see R3
        break_downscale_in     ? DATA_W'(DOWNSCALE_BRK) : // see R8
                                 up_code;

    // inputs are active low: report one while pin sits low
    wire logic disc_d = ~discrete_pin_in;           // see R5, see R4

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            enc_value_out    <= RST_WORD;
            enc_negative_out <= 1'b0;
            discrete_bit_out <= 1'b0;
        end else begin
            enc_value_out    <= enc_d;
            enc_negative_out <= enc_d[DATA_W-1];    // see R7
            discrete_bit_out <= disc_d;
        end
    end

    // holding registers live in external flash; bank is read-only, see R6

    // ************************************************************
    // checks
    // ************************************************************
    chk_status_identify: assert property (@(posedge clk_sys_in) // see R10
        disable iff (!rst_b_in)
        identify_in |=> status_q[BIT_IDENTIFY])
        else $error("identify flag not reported");

    chk_status_default: assert property (@(posedge clk_sys_in) // see R11
        disable iff (!rst_b_in)
        default_mode_in |=> status_q[BIT_DEFAULT])
        else $error("default flag not reported");

    chk_status_unused: assert property (@(posedge clk_sys_in) // see R12
        disable iff (!rst_b_in)
        rd_valid_out && $past(hit_status) |->
            rd_data_out[15] == 1'b0 && rd_data_out[12:0] == 13'h0000)
        else $error("unused status bits not zero");

    chk_range_width: assert property (@(posedge clk_sys_in) // see R13
        disable iff (!rst_b_in)
        rd_req_in && hit_rlow ##1 rd_valid_out |->
            rd_data_out == DATA_W'($past(range_low_in, 2)))
        else $error("range register wrong");

    chk_break_down: assert property (@(posedge clk_sys_in) // see R8
        disable iff (!rst_b_in)
        open_sensor_detect_in && break_downscale_in |=>
            enc_value_out == 16'h8000)
        else $error("downscale code wrong");

    chk_break_up_j: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_J |=> enc_value_out == 16'h325F)
        else $error("upscale J code wrong");

    chk_value_pass: assert property (@(posedge clk_sys_in) // see R2
        disable iff (!rst_b_in)
        !open_sensor_detect_in |=> enc_value_out == $past(conv_value_in))
        else $error("value not passed");

    chk_sign_flag: assert property (@(posedge clk_sys_in) // see R7
        disable iff (!rst_b_in)
        enc_negative_out == (enc_value_out >= 16'h8000))
        else $error("sign flag wrong");

    chk_discrete_low: assert property (@(posedge clk_sys_in) // see R5
        disable iff (!rst_b_in)
        !discrete_pin_in |=> discrete_bit_out)
        else $error("active-low input not reported");

    chk_read_latency: assert property (@(posedge clk_sys_in) // see R14
        disable iff (!rst_b_in)
        rd_req_in |=> rd_valid_out ##1 (!rd_valid_out || $past(rd_req_in)))
        else $error("read answer timing wrong");

    // flags must also drop once their source drops
    chk_identify_clear: assert property (@(posedge clk_sys_in) // see R10
        disable iff (!rst_b_in)
        !identify_in |=> !status_q[BIT_IDENTIFY])
        else $error("identify flag stuck");

    chk_default_clear: assert property (@(posedge clk_sys_in) // see R11
        disable iff (!rst_b_in)
        !default_mode_in |=> !status_q[BIT_DEFAULT])
        else $error("default flag stuck");

    chk_status_zero: assert property (@(posedge clk_sys_in) // see R12
        disable iff (!rst_b_in)
        status_q[15] == 1'b0 && status_q[12:0] == 13'h0000)
        else $error("status spare bits set");

    chk_range_high: assert property (@(posedge clk_sys_in) // see R13
        disable iff (!rst_b_in)
        rd_req_in && hit_rhigh ##1 rd_valid_out |->
            rd_data_out == DATA_W'($past(range_high_in, 2)))
        else $error("range high register wrong");

    chk_range_upper: assert property (@(posedge clk_sys_in) // see R13
        disable iff (!rst_b_in)
        rd_valid_out && $past(hit_rlow || hit_rhigh) |->
            rd_data_out[15:4] == 12'h000)
        else $error("range spare bits set");

    chk_read_unmapped: assert property (@(posedge clk_sys_in) // see R14
        disable iff (!rst_b_in)
        rd_req_in && rd_addr_in > 16'h0004 |=>
            rd_error_out && rd_data_out == 16'h0000)
        else $error("unmapped read not refused");

    chk_read_mapped: assert property (@(posedge clk_sys_in) // see R14
        disable iff (!rst_b_in)
        rd_req_in && rd_addr_in <= 16'h0004 |=>
            rd_valid_out && !rd_error_out)
        else $error("mapped read refused");

    // one check per upscale detent, literals kept apart from the table
    chk_break_up_k: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_K |=> enc_value_out == 16'h4E64)
        else $error("upscale K code wrong");

    chk_break_up_t: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_T |=> enc_value_out == 16'h1AA4)
        else $error("upscale T code wrong");

    chk_break_up_r: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_R |=> enc_value_out == 16'h79D6)
        else $error("upscale R code wrong");

    chk_break_up_s: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_S |=> enc_value_out == 16'h7FFF)
        else $error("upscale S code wrong");

    chk_break_up_e: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_E |=> enc_value_out == 16'h4EED)
        else $error("upscale E code wrong");

    chk_break_up_b: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_B |=> enc_value_out == 16'h5928)
        else $error("upscale B code wrong");

    chk_break_up_n: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in == RNG_TC_N |=> enc_value_out == 16'h520A)
        else $error("upscale N code wrong");

    // millivolt and reserved selectors share the positive ceiling
    chk_break_up_mv: assert property (@(posedge clk_sys_in) // see R9
        disable iff (!rst_b_in)
        open_sensor_detect_in && !break_downscale_in &&
            enc_range_in >= 4'h8 |=> enc_value_out == 16'h7FFF)
        else $error("upscale millivolt code wrong");

    chk_discrete_high: assert property (@(posedge clk_sys_in) // see R5
        disable iff (!rst_b_in)
        discrete_pin_in |=> !discrete_bit_out)
        else $error("idle input reported active");

endmodule

// File: include/tc_input_pkg.sv
// constants for the thermocouple input register bank
package tc_input_pkg;

    // ************************************************************
    // register offsets (word index within input-register space)
    // ************************************************************
    localparam logic [15:0] OFS_MODULE_STATUS  = 16'h0000;
    localparam logic [15:0] OFS_RANGE_LOW      = 16'h0001;
    localparam logic [15:0] OFS_RANGE_HIGH     = 16'h0002;
    localparam logic [15:0] OFS_JCOMP_LOW      = 16'h0003;
    localparam logic [15:0] OFS_JCOMP_HIGH     = 16'h0004;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_IDENTIFY    = 14;
    localparam int BIT_DEFAULT     = 13;
    localparam int RANGE_MSB       = 3;

    // ************************************************************
    // values after reset
    // ************************************************************
    localparam logic [3:0]  RST_RANGE  = 4'h0;
    localparam logic        RST_JCOMP  = 1'b0;
    localparam logic [15:0] RST_WORD   = 16'h0000;

    // ************************************************************
    // value encodings
    // ************************************************************
    localparam logic [15:0] PCT_FULL_POS  = 16'h4E20;  // +20000 = +100 %
    localparam logic [15:0] PCT_FULL_NEG  = 16'hB1E0;  // -20000 = -100 %
    localparam logic [15:0] TEMP_LSB_MC   = 16'h0064;  // 100 mdegC per lsb
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;  // 65535
    localparam logic [15:0] DOWNSCALE_BRK = 16'h8000;  // 32768
    localparam logic [15:0] UP_BRK_J      = 16'h325F;  // 12895
    localparam logic [15:0] UP_BRK_K      = 16'h4E64;  // 20068
    localparam logic [15:0] UP_BRK_T      = 16'h1AA4;  // 6820
    localparam logic [15:0] UP_BRK_R      = 16'h79D6;  // 31190
    localparam logic [15:0] UP_BRK_S      = 16'h7FFF;  // 32767
    localparam logic [15:0] UP_BRK_E      = 16'h4EED;  // 20205
    localparam logic [15:0] UP_BRK_B      = 16'h5928;  // 22824
    localparam logic [15:0] UP_BRK_N      = 16'h520A;  // 21002

    // ************************************************************
    // range selector codes
    // ************************************************************
    typedef enum logic [3:0] {
        RNG_TC_J   = 4'b0000,
        RNG_TC_K   = 4'b0001,
        RNG_TC_T   = 4'b0010,
        RNG_TC_R   = 4'b0011,
        RNG_TC_S   = 4'b0100,
        RNG_TC_E   = 4'b0101,
        RNG_TC_B   = 4'b0110,
        RNG_TC_N   = 4'b0111,
        RNG_MV100  = 4'b1000,
        RNG_V1     = 4'b1001
    } range_sel_t;

endpackage

// File: test/modbus_client_model.sv
// reading client that fetches one input register per go pulse
`timescale 1ns/1ps
module modbus_client_model (
    input  wire logic        clk_in,      // system clock
    input  wire logic        rst_b_in,    // sync reset, active low
    input  wire logic        go_in,       // start one read
    input  wire logic [15:0] addr_in,     // word offset wanted
    input  wire logic        rd_valid_in, // answer strobe
    input  wire logic        rd_error_in, // unmapped offset
    input  wire logic [15:0] rd_data_in,  // answered word
    output logic             rd_req_out,  // read strobe, one cycle
    output logic [15:0]      rd_addr_out, // offset to read
    output logic [15:0]      data_out,    // last word returned
    output logic             error_out,   // last error returned
    output logic             done_out     // answer captured
);
    // ************************************************************
    // request and capture
    // ************************************************************
    // reads only: no write path exists at all
    always_ff @(posedge clk_in) begin
        rd_req_out  <= rst_b_in & go_in;
        // idle address keeps toggling so nothing leans on a stale value
        rd_addr_out <= go_in ? addr_in : ~rd_addr_out;
        done_out    <= rst_b_in & rd_valid_in;
        if (rd_valid_in) begin
            data_out  <= rd_data_in;
            error_out <= rd_error_in;
        end
    end
endmodule

// File: test/tc_input_register_map_tb.sv
// self-checking bench for the thermocouple input register bank
`timescale 1ns/1ps
module tc_input_register_map_tb;
    import tc_input_pkg::*;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic        clk_sys_in = 1'b0;          // 50 MHz
    logic        rst_b_in   = 1'b0;          // held low at start
    logic        identify, dflt, jc_lo, jc_hi, brk, dn, pin;
    logic [3:0]  rng_lo, rng_hi, enc_rng;    // selectors
    logic [15:0] conv, ad, ev;               // value, offset, expected
    logic        go = 1'b0;                  // asks client for a read
    logic [15:0] go_addr = 16'h0000;
    logic        rd_req, rd_valid, rd_error, cl_err, cl_done, neg, disc;
    logic [15:0] rd_addr, rd_data, cl_data, enc_val;
    logic [15:0] corner [4] = '{16'h7FFF, 16'h8000, PCT_FULL_POS,
                                PCT_FULL_NEG};
    int          miscompares  = 0;
    int          total_checks = 0;

    tc_input_register_map #(.DATA_W(16)) tc_input_register_map_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .identify_in(identify), .default_mode_in(dflt),
        .range_low_in(rng_lo), .range_high_in(rng_hi),
        .jcomp_off_low_in(jc_lo), .jcomp_off_high_in(jc_hi),
        .conv_value_in(conv), .open_sensor_detect_in(brk),
        .break_downscale_in(dn), .enc_range_in(enc_rng),
        .discrete_pin_in(pin), .enc_value_out(enc_val),
        .enc_negative_out(neg), .discrete_bit_out(disc),
        .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .rd_error_out(rd_error));

    modbus_client_model modbus_client_model_inst (
        .clk_in(clk_sys_in), .rst_b_in(rst_b_in), .go_in(go),
        .addr_in(go_addr), .rd_valid_in(rd_valid), .rd_error_in(rd_error),
        .rd_data_in(rd_data), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
        .data_out(cl_data), .error_out(cl_err), .done_out(cl_done));

    // ************************************************************
    // clock, helpers and expectations
    // ************************************************************
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rnd_in();
        {identify, dflt, jc_lo, jc_hi, brk, dn, pin} = 7'($urandom);
        {rng_lo, rng_hi, enc_rng} = 12'($urandom);
        conv = 16'($urandom);
    endtask

    // one read through the client, bounded wait for its answer
    task automatic rd(input logic [15:0] a);
        int n;
        n = 0;
        go = 1'b1;
        go_addr = a;
        @(posedge clk_sys_in);
        #1 go = 1'b0;
        while (cl_done !== 1'b1 && n < 10) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
        if (n >= 10) begin
            miscompares++;
            $display("[FAIL] read answer expected 1 seen 0");
        end
    endtask

    function automatic logic [15:0] exp_reg(input logic [15:0] a);
        case (a)
            16'h0000: return {1'b0, identify, dflt, 13'h0000};
            16'h0001: return {12'h000, rng_lo};
            16'h0002: return {12'h000, rng_hi};
            16'h0003: return {15'h0000, jc_lo};
            16'h0004: return {15'h0000, jc_hi};
            default:  return 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] exp_enc();
        if (!brk) return conv;
        if (dn) return DOWNSCALE_BRK;
        case (enc_rng)
            4'h0: return UP_BRK_J;
            4'h1: return UP_BRK_K;
            4'h2: return UP_BRK_T;
            4'h3: return UP_BRK_R;
            4'h4: return UP_BRK_S;
            4'h5: return UP_BRK_E;
            4'h6: return UP_BRK_B;
            4'h7: return UP_BRK_N;
            default: return 16'h7FFF;
        endcase
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog: the run needs well under a thousand cycles
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        void'($urandom(32'hD47C2331));
        rnd_in();
        repeat (8) @(posedge clk_sys_in);
        #1 rst_b_in = 1'b1;
        // every flag pair, all offsets and two unmapped ones
        for (int k = 0; k < 8; k++) begin
            rnd_in();
            {identify, dflt} = 2'(k);
            for (int a = 0; a < 7; a++) begin
                ad = (a == 6) ? 16'($urandom_range(65535, 6)) : 16'(a);
                rd(ad);
                chk("read data", exp_reg(ad), cl_data);
                chk("read error", 16'(ad > 4), 16'(cl_err));
            end
        end
        $display("test register reads done");
        // every selector with no break, upscale and downscale break
        for (int k = 0; k < 48; k++) begin
            rnd_in();
            enc_rng = 4'(k);
            {brk, dn} = {k >= 16, k >= 32};
            if (k < 4) conv = corner[k];
            ev = exp_enc();
            @(posedge clk_sys_in);
            #1;
            chk("encoded value", ev, enc_val);
            chk("negative flag", 16'(ev[15]), 16'(neg));
            chk("discrete bit", {15'h0000, ~pin}, 16'(disc));
        end
        $display("test value encoder done");
        finish_test();
    end
endmodule
